// ===== design/wdtc_top.sv
// watchdog timer with control register, apb slave and interrupt
//
// Summary of operation
// - watchdog ticks from internal rc oscillator; oscillator on while enabled
// - base period of nominally 4 ms made from rc clock
// - 16-bit postscaler after base period; scale field picks output
// - scale code n from 0 to 15 divides by two to the n
// - scale field is write-once, unprogrammed all ones
// - upper four bits of period config read zero
// - kick, sleep or oscillator failure clear counter and postscaler
// - fused enable one runs watchdog; zero defers to software bit
// - control bit 0 turns watchdog on or off only without fuse
// - control register read/write; writable bits reset to zero
// - control bit 6 shows live core supply level while regulator enabled, else zero, read only
// - control bit 7 sends regulator low-power during sleep
// - low core-voltage detect clears regulator sleep bit
// - control bit 4 selects which shared-address bank is mapped
// - control bits 5 and 3 to 1 read zero
//
// The APB slave port is this design's own decision.
`include "wdtc_consts.svh"
`timescale 1ns/10ps
module wdtc_top
    import wdtc_pkg::*;
#(
    parameter int RC_HZ = `WDTC_RC_HZ,
    parameter int BASE_TICKS = RC_HZ * `WDTC_BASE_US / `WDTC_US_PER_S,
    parameter int POST_W = 16
)(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core events and pins
    input wire wdtc_evt_s evt,
    input wire logic sleeping,
    input wire logic rc_clk_pin,
    input wire logic fused_watchdog_on,
    input wire logic core_undervolt_level,
    input wire logic regulator_enabled,
    // outputs to the rest of the chip
    output logic internal_rc_oscillator_on,
    output logic wdt_reset,
    output logic wdt_wakeup,
    output logic regulator_sleep_lowpower,
    output logic shared_bank_select,
    output logic irq
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    localparam int BASE_W = $clog2(BASE_TICKS + 1);
    localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(BASE_TICKS - 1);

    // postscaler terminal count for a scale code
    function automatic logic [POST_W-1:0] post_limit(input wdtc_scale_t c);
        post_limit = POST_W'((32'h1 << c) - 32'h1);
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [3:0] sy1_q, sy1_d, sy2_q, sy2_d;
    logic rc_prev_q, rc_prev_d, uv_prev_q, uv_prev_d;
    logic rc_s, fuse_s, uv_s, reg_en_s, rc_edge, lvd_fall;

    // first stage is read by the second stage only
    always_comb
    begin
        sy1_d = {regulator_enabled, core_undervolt_level,
                 fused_watchdog_on, rc_clk_pin};
        sy2_d = sy1_q;
        rc_prev_d = sy2_q[0];
        uv_prev_d = sy2_q[2];
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sy1_q <= 4'h0;
            sy2_q <= 4'h0;
            rc_prev_q <= 1'b0;
            uv_prev_q <= 1'b0;
        end
        else
        begin
            sy1_q <= sy1_d;
            sy2_q <= sy2_d;
            rc_prev_q <= rc_prev_d;
            uv_prev_q <= uv_prev_d;
        end
    end

    assign rc_s = sy2_q[0];
    assign fuse_s = sy2_q[1];
    assign uv_s = sy2_q[2] & reg_en_s;
    assign reg_en_s = sy2_q[3];
    assign rc_edge = rc_s & ~rc_prev_q;
    // detect only meaningful with the regulator running
    assign lvd_fall = uv_prev_q & ~sy2_q[2] & reg_en_s;

    // ---------------------------------------------------------------
    // registers and apb slave
    // ---------------------------------------------------------------
    wdtc_scale_t scale_q, scale_d;
    logic prog_q, prog_d, soft_q, soft_d, slp_q, slp_d, bank_q, bank_d;
    logic [`WDTC_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, ev_set;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d, setup, wr, run, expire;
    logic hit_cfg, hit_ctrl, hit_stat, hit_mask;

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign hit_cfg = paddr == `WDTC_CFG_ADDR;
    assign hit_ctrl = paddr == `WDTC_CTRL_ADDR;
    assign hit_stat = paddr == `WDTC_IRQ_STAT_ADDR;
    assign hit_mask = paddr == `WDTC_IRQ_MASK_ADDR;
    assign ev_set = {lvd_fall, expire};

    // next state of every software visible register
    always_comb
    begin
        scale_d = scale_q;
        prog_d = prog_q;
        soft_d = soft_q;
        slp_d = slp_q;
        bank_d = bank_q;
        mask_d = mask_q;
        rdata_d = rdata_q;
        err_d = err_q;
        if (wr && hit_cfg && !prog_q)
        begin
            scale_d = pwdata[3:0];
            prog_d = 1'b1;
        end
        if (wr && hit_ctrl)
        begin
            soft_d = pwdata[`WDTC_CTRL_SOFT_ON];
            slp_d = pwdata[`WDTC_CTRL_REGULATOR_SLEEP_LOWPOWER];
            bank_d = pwdata[`WDTC_CTRL_BANK];
        end
        // hardware clear beats a same-cycle software set
        if (lvd_fall)
            slp_d = 1'b0;
        if (wr && hit_mask)
            mask_d = pwdata[`WDTC_IRQ_W-1:0];
        // write one clears, a new event wins over the clear
        stat_d = stat_q;
        if (wr && hit_stat)
            stat_d = stat_q & ~pwdata[`WDTC_IRQ_W-1:0];
        stat_d = stat_d | ev_set;
        // read data and error prepared in the setup cycle
        if (setup)
        begin
            err_d = ~(hit_cfg | hit_ctrl | hit_stat | hit_mask);
            rdata_d = 32'h0;
            if (!pwrite && hit_cfg)
                rdata_d = {28'h0, scale_q};
            if (!pwrite && hit_ctrl)
                rdata_d = {24'h0, slp_q, uv_s, 1'b0, bank_q,
                           3'h0, soft_q};
            if (!pwrite && hit_stat)
                rdata_d = {30'h0, stat_q};
            if (!pwrite && hit_mask)
                rdata_d = {30'h0, mask_q};
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scale_q <= `WDTC_CFG_SCALE_RST;
            prog_q <= 1'b0;
            soft_q <= 1'b0;
            slp_q <= 1'b0;
            bank_q <= 1'b0;
            stat_q <= '0;
            mask_q <= '0;
            rdata_q <= 32'h0;
            err_q <= 1'b0;
        end
        else
        begin
            scale_q <= scale_d;
            prog_q <= prog_d;
            soft_q <= soft_d;
            slp_q <= slp_d;
            bank_q <= bank_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // zero-wait slave, error only on unmapped addresses
    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign pslverr = psel & penable & err_q;
    assign irq = |(stat_q & mask_q);
    assign shared_bank_select = bank_q;

    // ---------------------------------------------------------------
    // base counter, postscaler and expiry
    // ---------------------------------------------------------------
    logic [BASE_W-1:0] base_q, base_d;
    logic [POST_W-1:0] post_q, post_d;
    wdtc_act_e act_q, act_d;
    logic osc_q, osc_d, lp_q, lp_d, clr, base_done;

    assign run = fuse_s | soft_q;
    assign clr = evt.kick | evt.sleep | evt.osc_fail | ~run;
    assign base_done = rc_edge & (base_q == BASE_LAST);
    // at or past the selected tap, so a smaller scale programmed while
    // counting ends the period instead of wrapping the postscaler
    assign expire = ~clr & base_done &
                    (post_q >= post_limit(scale_q));

    always_comb
    begin
        base_d = base_q;
        post_d = post_q;
        if (clr || expire)
        begin
            base_d = '0;
            post_d = '0;
        end
        else if (base_done)
        begin
            base_d = '0;
            post_d = post_q + POST_W'(1);
        end
        else if (rc_edge)
            base_d = base_q + BASE_W'(1);
        act_d = WDTC_IDLE;
        if (expire)
            act_d = sleeping ? WDTC_WAKE : WDTC_RESET;
        osc_d = run;
        lp_d = slp_q & sleeping;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            base_q <= '0;
            post_q <= '0;
            act_q <= WDTC_IDLE;
            osc_q <= 1'b0;
            lp_q <= 1'b0;
        end
        else
        begin
            base_q <= base_d;
            post_q <= post_d;
            act_q <= act_d;
            osc_q <= osc_d;
            lp_q <= lp_d;
        end
    end

    assign wdt_reset = act_q == WDTC_RESET;
    assign wdt_wakeup = act_q == WDTC_WAKE;
    assign internal_rc_oscillator_on = osc_q;
    assign regulator_sleep_lowpower = lp_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_osc_follows_run: assert property (
        run |=> internal_rc_oscillator_on)
        else $error("rc oscillator off while watchdog runs");

    a_base_len: assert property (
        rc_edge && !clr && !base_done
            |=> base_q == $past(base_q) + BASE_W'(1))
        else $error("base counter did not advance on rc edge");

    a_base_bound: assert property (
        base_q <= BASE_LAST)
        else $error("base counter past its last count");

    a_tap_limit: assert property (
        base_done && !clr && post_q == POST_W'((32'h1 << scale_q) - 32'h1)
            |=> post_q == '0 && (wdt_reset || wdt_wakeup))
        else $error("selected postscaler tap did not end the timeout");

    a_cfg_write_once: assert property (
        prog_q && wr && hit_cfg |=> $stable(scale_q))
        else $error("scale field changed after programming");

    a_cfg_upper_zero: assert property (
        setup && !pwrite && hit_cfg |=> prdata[7:4] == 4'h0)
        else $error("config upper bits not zero");

    a_clear_counts: assert property (
        clr |=> base_q == '0 && post_q == '0)
        else $error("counters not cleared");

    a_fuse_runs: assert property (
        fuse_s && !evt.kick && !evt.sleep && !evt.osc_fail |-> !clr)
        else $error("fused watchdog not running");

    a_soft_enable: assert property (
        wr && hit_ctrl && pwdata[0] |=> run)
        else $error("software enable ignored");

    a_ctrl_unused: assert property (
        setup && !pwrite && hit_ctrl |=> prdata[5] == 1'b0
            && prdata[3:1] == 3'h0)
        else $error("unused control bits not zero");

    a_lvd_clears_slp: assert property (
        lvd_fall |=> !slp_q)
        else $error("regulator sleep bit not cleared");

    a_expire_action: assert property (
        expire |=> (wdt_reset ^ wdt_wakeup) ##1 !wdt_reset && !wdt_wakeup)
        else $error("expiry action not a single pulse");

    a_timeout_sticky: assert property (
        stat_q[`WDTC_IRQ_TIMEOUT] && !(wr && hit_stat)
            |=> stat_q[`WDTC_IRQ_TIMEOUT])
        else $error("timeout flag lost without a clear");

    a_undervolt_gate: assert property (
        setup && !pwrite && hit_ctrl && !reg_en_s
            |=> !prdata[`WDTC_CTRL_UNDERVOLT])
        else $error("core level shown with regulator off");

    a_sleep_lowpower: assert property (
        slp_q && sleeping |=> regulator_sleep_lowpower)
        else $error("regulator not low-power in sleep");

    a_bank_select: assert property (
        wr && hit_ctrl
            |=> shared_bank_select == $past(pwdata[`WDTC_CTRL_BANK]))
        else $error("shared bank select not written");

endmodule

// ===== design/wdtc_consts.svh
// constants for the watchdog timer with control block
`ifndef WDTC_CONSTS_SVH
`define WDTC_CONSTS_SVH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define WDTC_CFG_IDX 32'h0030_0003
`define WDTC_CFG_ADDR 32'h00c0_000c
`define WDTC_CTRL_ADDR 32'h0000_0000
`define WDTC_IRQ_STAT_ADDR 32'h0000_0004
`define WDTC_IRQ_MASK_ADDR 32'h0000_0008

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define WDTC_CTRL_SOFT_ON 0
`define WDTC_CTRL_BANK 4
`define WDTC_CTRL_UNDERVOLT 6
`define WDTC_CTRL_REGULATOR_SLEEP_LOWPOWER 7
`define WDTC_CFG_SCALE_RST 4'hf
`define WDTC_IRQ_TIMEOUT 0
`define WDTC_IRQ_LVD 1
`define WDTC_IRQ_W 2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define WDTC_BASE_US 4000
`define WDTC_RC_HZ 32000
`define WDTC_US_PER_S 1000000

`endif

// ===== design/wdtc_pkg.sv
// types shared by the watchdog timer with control block
package wdtc_pkg;

    // instruction and clock-monitor events, all one-cycle pulses
    typedef struct packed {
        logic kick;
        logic sleep;
        logic osc_fail;
    } wdtc_evt_s;

    // what the watchdog does when the selected output expires
    typedef enum logic [1:0] {
        WDTC_IDLE,
        WDTC_RESET,
        WDTC_WAKE
    } wdtc_act_e;

    typedef logic [3:0] wdtc_scale_t;

endpackage

// ===== bench/wdtc_top_tb.sv
// self-checking testbench for the watchdog timer with control block
`timescale 1ns/10ps
`include "wdtc_consts.svh"
`define CHK(nm, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
        end \
    end

module wdtc_top_tb
    import wdtc_pkg::*;
;
    // ---------------------------------------------------------------
    // signals and model state
    // ---------------------------------------------------------------
    // short base period keeps every timeout within a few hundred cycles
    localparam int BT = 2;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic sleeping, rc, fuse, uv, reg_en, osc_on, wrst, wwake, lp, bank, irq;
    logic [31:0] paddr, pwdata, prdata, rd_q;
    wdtc_evt_s evt;
    int mismatches, comparisons, n_rst, n_wake, exp_rst, exp_wake, seed, s;
    int scales[$];

    wdtc_top #(.BASE_TICKS(BT)) u_dut (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evt(evt), .sleeping(sleeping),
        .rc_clk_pin(rc), .fused_watchdog_on(fuse),
        .core_undervolt_level(uv), .regulator_enabled(reg_en),
        .internal_rc_oscillator_on(osc_on), .wdt_reset(wrst),
        .wdt_wakeup(wwake), .regulator_sleep_lowpower(lp),
        .shared_bank_select(bank), .irq(irq));

    // pulses are counted per cycle, so a stretched pulse shows as extra
    always @(posedge mclk)
    begin
        if (wrst === 1'b1) n_rst++;
        if (wwake === 1'b1) n_wake++;
    end

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one apb transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge mclk);
        end
        if (n >= 20)
        begin
            mismatches++;
            test_done();
        end
        rd_q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd_q)
    endtask

    task automatic edges(input int k);
        repeat (k)
        begin
            @(posedge mclk) rc <= 1'b1;
            repeat (4) @(posedge mclk);
            rc <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask

    task automatic do_reset();
        @(posedge mclk) rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic counts();
        `CHK("resets", exp_rst, n_rst)
        `CHK("wakes", exp_wake, n_wake)
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        {rst_b, psel, penable, pwrite, sleeping, rc, fuse} = '0;
        {paddr, pwdata, evt, uv, reg_en} = '0;
        uv = 1'b1; reg_en = 1'b1; seed = 12;
        do_reset();
        rd(`WDTC_CTRL_ADDR, 32'h0000_0040, "ctrl");
        rd(`WDTC_CFG_ADDR, 32'h0000_000f, "cfg");
        rd(`WDTC_IRQ_STAT_ADDR, 32'h0000_0000, "stat");
        rd(32'h0000_0010, 32'h0000_0000, "unmapped");
        `CHK("slverr", 1'b1, err)
        apb(1'b1, `WDTC_CTRL_ADDR, 32'h0000_00ff);
        rd(`WDTC_CTRL_ADDR, 32'h0000_00d1, "ctrl");
        `CHK("bank", 1'b1, bank)
        apb(1'b1, `WDTC_CTRL_ADDR, 32'h0000_0080);
        sleeping <= 1'b1;
        repeat (2) @(posedge mclk);
        `CHK("lowpower", 1'b1, lp)
        uv <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(`WDTC_CTRL_ADDR, 32'h0000_0000, "ctrl");
        `CHK("lowpower", 1'b0, lp)
        sleeping <= 1'b0;
        rd(`WDTC_IRQ_STAT_ADDR, 32'h0000_0002, "stat");
        `CHK("irq", 1'b0, irq)
        apb(1'b1, `WDTC_IRQ_MASK_ADDR, 32'h0000_0002);
        // the mask lands at the access edge; look one edge later
        @(posedge mclk);
        `CHK("irq", 1'b1, irq)
        apb(1'b1, `WDTC_IRQ_STAT_ADDR, 32'h0000_0002);
        rd(`WDTC_IRQ_STAT_ADDR, 32'h0000_0000, "stat");
        `CHK("irq", 1'b0, irq)
        // live level shows only while the regulator runs
        uv <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(`WDTC_CTRL_ADDR, 32'h0000_0040, "ctrl");
        reg_en <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(`WDTC_CTRL_ADDR, 32'h0000_0000, "ctrl");
        reg_en <= 1'b1;
        // each scale needs a fresh reset, the field being write-once
        scales = '{0, 1, 3};
        scales.push_back($unsigned($random(seed)) % 5);
        foreach (scales[i])
        begin
            s = scales[i];
            do_reset();
            apb(1'b1, `WDTC_CFG_ADDR, 32'hffff_fff0 | s);
            apb(1'b1, `WDTC_CFG_ADDR, 32'h0000_000f ^ s);
            rd(`WDTC_CFG_ADDR, s, "cfg");
            apb(1'b1, `WDTC_CTRL_ADDR, 32'h0000_0001);
            repeat (4) @(posedge mclk);
            `CHK("osc_on", 1'b1, osc_on)
            edges(BT * (1 << s) - 1);
            counts();
            edges(1);
            exp_rst++;
            counts();
            rd(`WDTC_IRQ_STAT_ADDR, 32'h0000_0001, "stat");
        end
        // fuse alone runs it; a cleared soft bit is then ignored
        do_reset();
        apb(1'b1, `WDTC_CFG_ADDR, 32'h0000_0001);
        `CHK("osc_on", 1'b0, osc_on)
        fuse <= 1'b1;
        repeat (5) @(posedge mclk);
        apb(1'b1, `WDTC_CTRL_ADDR, 32'h0000_0000);
        `CHK("osc_on", 1'b1, osc_on)
        edges(2 * BT);
        exp_rst++;
        counts();
        fuse <= 1'b0;
        repeat (5) @(posedge mclk);
        edges(2 * BT);
        counts();
        apb(1'b1, `WDTC_CTRL_ADDR, 32'h0000_0001);
        repeat (4) @(posedge mclk);
        // kick, sleep and clock failure each restart the full period
        for (int k = 0; k < 3; k++)
        begin
            edges(2 * BT - 1);
            @(posedge mclk) evt[k] <= 1'b1;
            @(posedge mclk) evt <= '0;
            sleeping <= (k == 1);
            edges(2 * BT - 1);
            counts();
            edges(1);
            if (k == 1) exp_wake++;
            else exp_rst++;
            counts();
            sleeping <= 1'b0;
        end
        test_done();
    end
endmodule
